// ### rtl/fmc_mem.sv
`default_nettype none

// small register array; read data is registered one cycle after the address
module fmc_mem #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 12,
   parameter int AW = 4,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [WIDTH-1:0] wdata,
   input wire logic [AW-1:0] raddr,
   output logic [WIDTH-1:0] rdata
);

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [WIDTH-1:0] rdata_r;
   logic [WIDTH-1:0] rdata_nxt;

   // every entry has its own reset so all fields recover on any reset
   for (genvar i = 0; i < DEPTH; i++) begin : g_word
      logic [WIDTH-1:0] word_nxt;
      always_comb begin
         word_nxt = mem_r[i];
         if (we && (waddr == AW'(i))) begin
            word_nxt = wdata;
         end
      end
      always_ff @(posedge clk or posedge rst) begin
         if (rst) begin
            mem_r[i] <= RST_VAL;
         end else begin
            mem_r[i] <= word_nxt;
         end
      end
   end

   // out-of-range index reads zero rather than x
   always_comb begin
      rdata_nxt = '0;
      if (32'(raddr) < DEPTH) begin
         rdata_nxt = mem_r[raddr];
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata_r <= '0;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   assign rdata = rdata_r;

endmodule

`default_nettype wire

// ### rtl/fmc_pkg.sv
`default_nettype none

package fmc_pkg;

   // register geometry
   localparam int DATA_W = 24;
   localparam int ADDR_W = 7;
   localparam int IDX_W = 4;
   localparam int NUM_REGS = 12;

   // serial frame: one command byte, then one whole register word
   localparam int CMD_BITS = 8;
   localparam int CMD_READ_POS = 7;
   localparam logic [5:0] CMD_LAST_BIT = 6'h07;
   localparam logic [5:0] DATA_LAST_BIT = 6'h17;

   // register addresses
   localparam logic [ADDR_W-1:0] ADDR_MODEM_CONTROL = 7'h00;
   localparam logic [ADDR_W-1:0] ADDR_RX_TX_CONTROL = 7'h01;
   localparam logic [ADDR_W-1:0] ADDR_RX_CONTROL_EXT_ONE = 7'h02;
   localparam logic [ADDR_W-1:0] ADDR_RX_CONTROL_EXT_TWO = 7'h03;
   localparam logic [ADDR_W-1:0] ADDR_RX_BIT_DETECT_THRESHOLD = 7'h04;
   localparam logic [ADDR_W-1:0] ADDR_RX_CARRIER_UP_THRESHOLD = 7'h05;
   localparam logic [ADDR_W-1:0] ADDR_RX_CARRIER_DOWN_THRESHOLD = 7'h06;
   localparam logic [ADDR_W-1:0] ADDR_RX_CARRIER_OUTPUT_THRESHOLD = 7'h07;
   localparam logic [ADDR_W-1:0] ADDR_TX_MARK_SPACE_COUNTS = 7'h08;
   localparam logic [ADDR_W-1:0] ADDR_MODEM_STATUS = 7'h09;
   localparam logic [ADDR_W-1:0] ADDR_ANALOG_TRIM = 7'h0a;
   localparam logic [ADDR_W-1:0] ADDR_TEST_MODE = 7'h0b;
   localparam logic [ADDR_W-1:0] ADDR_LAST = 7'h0b;

   // modem_control fields
   localparam int CTRL_TEST_EN_POS = 0;
   localparam logic CTRL_TEST_EN_RST = 1'b0;

   // rx_tx_control fields
   localparam int RXTX_SLEW_CLK_POS = 23;
   localparam int RXTX_DIS_EDGE_POS = 22;
   localparam int RXTX_DC_LOAD_POS = 21;
   localparam int RXTX_BUF_EN_POS = 20;
   localparam int RXTX_PWR_DLY_LSB = 16;
   localparam int RXTX_PWR_DLY_W = 4;
   localparam int RXTX_BP_SETTLE_LSB = 8;
   localparam int RXTX_BP_SETTLE_W = 8;
   localparam int RXTX_LOW_W = 8;
   // 23:1, 22:0, 21:1, 20:1, 19:16 0x2, 15:8 0x50, 7:0 0x43
   localparam logic [DATA_W-1:0] RXTX_RST = 24'hb25043;

   // other stored registers come out of reset cleared
   localparam logic [DATA_W-1:0] MEM_RST = 24'h000000;

   // pin mapping in adc linearity test mode
   localparam int GPIO_W = 6;
   localparam int ADC_W = 8;
   localparam int ADC_TAP_LSB = 2;

endpackage

`default_nettype wire

// ### rtl/fmc_regs.sv
// Operation
// [R01] registers are 24 bits, whole-word transfers
// [R02] reached only through internal serial port
// [R03] absolute addresses 0x00 to 0x0b decoded
// [R04] all fields reset on any reset
// [R05] control bit 0 enables adc test
// [R06] software also sets modem enable bit
// [R07] test mode forces rts, receive functional
// [R08] test mode puts adc bits on gpio
// [R09] bit 23 selects 2 or 4 mhz
// [R10] software adjusts mark-space counts for 2mhz
// [R11] bit 22 selects transmit disable edge
// [R12] bit 20 enables transmit output buffer
// [R13] bits 19:16 power-up ignore count
// [R14] software picks ignore count carefully
// [R15] bits 15:8 bandpass settle delay
// [R16] software disables modem before writing
// [R17] addresses above 0x0b read zero
`default_nettype none

module fmc_regs (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic spi_sclk,
   input wire logic spi_cs_n,
   input wire logic spi_mosi,
   output logic spi_miso,
   output logic spi_miso_en_n,
   input wire logic rts_gpio_n,
   input wire logic [fmc_pkg::ADC_W-1:0] rx_adc_result,
   input wire logic [fmc_pkg::GPIO_W-1:0] gpio_func_out,
   input wire logic [fmc_pkg::DATA_W-1:0] modem_status,
   output logic adc_linearity_test_enable,
   output logic modem_rts_n,
   output logic rx_functional_mode,
   output logic [fmc_pkg::GPIO_W-1:0] gpio_out,
   output logic tx_slew_clock_select,
   output logic tx_disable_edge_select,
   output logic tx_bus_dc_load_select,
   output logic tx_buffer_enable,
   output logic [fmc_pkg::RXTX_PWR_DLY_W-1:0] rx_power_up_ignore_count,
   output logic [fmc_pkg::RXTX_BP_SETTLE_W-1:0] rx_bandpass_settle_count
);

   // frame states, one-hot so each test is a single bit
   typedef enum logic [3:0] {
      FMC_IDLE = 4'b0001,
      FMC_CMD = 4'b0010,
      FMC_DATA = 4'b0100,
      FMC_DONE = 4'b1000
   } fmc_state_e;

   // pin synchronisers; the third stage only serves edge detection
   logic [2:0] sclk_s_r;
   logic [1:0] cs_s_r;
   logic [1:0] mosi_s_r;
   logic [1:0] rts_s_r;
   logic [2:0] sclk_s_nxt;
   logic [1:0] cs_s_nxt;
   logic [1:0] mosi_s_nxt;
   logic [1:0] rts_s_nxt;

   always_comb begin
      sclk_s_nxt = {sclk_s_r[1:0], spi_sclk};
      cs_s_nxt = {cs_s_r[0], spi_cs_n};
      mosi_s_nxt = {mosi_s_r[0], spi_mosi};
      rts_s_nxt = {rts_s_r[0], rts_gpio_n};
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sclk_s_r <= 3'h0;
         cs_s_r <= 2'h3;
         mosi_s_r <= 2'h0;
         rts_s_r <= 2'h3;
      end else begin
         sclk_s_r <= sclk_s_nxt;
         cs_s_r <= cs_s_nxt;
         mosi_s_r <= mosi_s_nxt;
         rts_s_r <= rts_s_nxt;
      end
   end

   logic sclk_rise;
   logic sclk_fall;
   logic cs_active;
   logic mosi_bit;

   // edges come from the synchronised copies, so each lasts one ref_clk cycle
   assign sclk_rise = sclk_s_r[1] & ~sclk_s_r[2]; // [R02]
   assign sclk_fall = ~sclk_s_r[1] & sclk_s_r[2];
   assign cs_active = ~cs_s_r[1];
   assign mosi_bit = mosi_s_r[1];

   // frame engine state
   fmc_state_e state_r, state_nxt;
   logic [5:0] bit_cnt_r, bit_cnt_nxt;
   logic [fmc_pkg::DATA_W-1:0] rx_sh_r, rx_sh_nxt;
   logic [fmc_pkg::DATA_W-1:0] tx_sh_r, tx_sh_nxt;
   logic [fmc_pkg::CMD_BITS-1:0] cmd_r, cmd_nxt;
   logic loaded_r, loaded_nxt;
   logic miso_r, miso_nxt;
   logic ctrl_test_r, ctrl_test_nxt;
   logic [fmc_pkg::DATA_W-1:0] rxtx_r, rxtx_nxt;

   logic [fmc_pkg::ADDR_W-1:0] reg_addr;
   logic cmd_is_read;
   logic addr_in_range;
   logic addr_in_mem;
   logic mem_we;
   logic [fmc_pkg::DATA_W-1:0] mem_wdata;
   logic [fmc_pkg::DATA_W-1:0] mem_rdata;
   logic [fmc_pkg::DATA_W-1:0] read_word;

   // command byte: bit 7 picks a read, bits 6:0 are the absolute address
   assign reg_addr = cmd_r[fmc_pkg::ADDR_W-1:0];
   assign cmd_is_read = cmd_r[fmc_pkg::CMD_READ_POS];
   // out-of-map addresses neither store nor answer
   assign addr_in_range = (reg_addr <= fmc_pkg::ADDR_LAST); // [R03] [R17]
   // registers with dedicated fields or live status are kept outside the array
   assign addr_in_mem = addr_in_range && (reg_addr != fmc_pkg::ADDR_MODEM_CONTROL)
      && (reg_addr != fmc_pkg::ADDR_RX_TX_CONTROL) && (reg_addr != fmc_pkg::ADDR_MODEM_STATUS);

   // the array answers one cycle after the address settles, long before the first fall
   // status is taken when the word is loaded, not frozen at the command
   // read mux; reserved control bits read zero, status is live
   always_comb begin
      read_word = '0;
      if (addr_in_range) begin // [R17]
         if (reg_addr == fmc_pkg::ADDR_MODEM_CONTROL) begin
            read_word[fmc_pkg::CTRL_TEST_EN_POS] = ctrl_test_r; // [R05]
         end else if (reg_addr == fmc_pkg::ADDR_RX_TX_CONTROL) begin
            read_word = rxtx_r;
         end else if (reg_addr == fmc_pkg::ADDR_MODEM_STATUS) begin
            read_word = modem_status;
         end else begin
            read_word = mem_rdata;
         end
      end
   end

   // one frame: 8 command bits then 24 data bits, msb first, sampled on rising sclk
   always_comb begin
      state_nxt = state_r;
      bit_cnt_nxt = bit_cnt_r;
      rx_sh_nxt = rx_sh_r;
      tx_sh_nxt = tx_sh_r;
      cmd_nxt = cmd_r;
      loaded_nxt = loaded_r;
      miso_nxt = miso_r;
      ctrl_test_nxt = ctrl_test_r;
      rxtx_nxt = rxtx_r;
      mem_we = 1'b0;
      mem_wdata = {rx_sh_r[fmc_pkg::DATA_W-2:0], mosi_bit};
      if (!cs_active) begin
         // deselect aborts any partial frame without touching registers
         state_nxt = FMC_IDLE;
         miso_nxt = 1'b0;
         loaded_nxt = 1'b0;
      end else begin
         unique case (state_r)
            FMC_IDLE: begin
               // a fresh select restarts the bit count and the read loader
               state_nxt = FMC_CMD;
               bit_cnt_nxt = 6'h00;
               loaded_nxt = 1'b0;
               miso_nxt = 1'b0;
            end
            FMC_CMD: begin
               // command bits collect in the low end of the shared shifter
               if (sclk_rise) begin
                  rx_sh_nxt = {rx_sh_r[fmc_pkg::DATA_W-2:0], mosi_bit};
                  bit_cnt_nxt = bit_cnt_r + 6'h01;
                  if (bit_cnt_r == fmc_pkg::CMD_LAST_BIT) begin
                     cmd_nxt = {rx_sh_r[fmc_pkg::CMD_BITS-2:0], mosi_bit};
                     bit_cnt_nxt = 6'h00;
                     state_nxt = FMC_DATA;
                  end
               end
            end
            FMC_DATA: begin
               // read data is launched on falling sclk so it is stable at the next rise
               // limitation: sclk half period must exceed the three-cycle synchroniser delay
               if (sclk_fall) begin
                  if (!loaded_r) begin
                     miso_nxt = read_word[fmc_pkg::DATA_W-1]; // [R01]
                     tx_sh_nxt = {read_word[fmc_pkg::DATA_W-2:0], 1'b0};
                     loaded_nxt = 1'b1;
                  end else begin
                     miso_nxt = tx_sh_r[fmc_pkg::DATA_W-1];
                     tx_sh_nxt = {tx_sh_r[fmc_pkg::DATA_W-2:0], 1'b0};
                  end
               end
               if (sclk_rise) begin
                  rx_sh_nxt = {rx_sh_r[fmc_pkg::DATA_W-2:0], mosi_bit};
                  bit_cnt_nxt = bit_cnt_r + 6'h01;
                  if (bit_cnt_r == fmc_pkg::DATA_LAST_BIT) begin
                     state_nxt = FMC_DONE;
                     // only a full 24-bit word commits; writes above the map vanish
                     if (!cmd_is_read && addr_in_range) begin // [R01] [R17]
                        if (reg_addr == fmc_pkg::ADDR_MODEM_CONTROL) begin
                           ctrl_test_nxt = mem_wdata[fmc_pkg::CTRL_TEST_EN_POS]; // [R05]
                        end else if (reg_addr == fmc_pkg::ADDR_RX_TX_CONTROL) begin
                           rxtx_nxt = mem_wdata; // [R09] [R11] [R12] [R13] [R15]
                        end else if (addr_in_mem) begin
                           mem_we = 1'b1;
                        end
                     end
                  end
               end
            end
            FMC_DONE: begin
               // extra clocks after the word are ignored until deselect
               miso_nxt = 1'b0;
            end
         endcase
      end
   end

   // frame engine and stored control words
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state_r <= FMC_IDLE;
         bit_cnt_r <= 6'h00;
         rx_sh_r <= '0;
         tx_sh_r <= '0;
         cmd_r <= '0;
         loaded_r <= 1'b0;
         miso_r <= 1'b0;
         ctrl_test_r <= fmc_pkg::CTRL_TEST_EN_RST; // [R04]
         rxtx_r <= fmc_pkg::RXTX_RST; // [R04]
      end else begin
         state_r <= state_nxt;
         bit_cnt_r <= bit_cnt_nxt;
         rx_sh_r <= rx_sh_nxt;
         tx_sh_r <= tx_sh_nxt;
         cmd_r <= cmd_nxt;
         loaded_r <= loaded_nxt;
         miso_r <= miso_nxt;
         ctrl_test_r <= ctrl_test_nxt;
         rxtx_r <= rxtx_nxt;
      end
   end

   // remaining registers live in a small array, reset to zero
   fmc_mem #(
      .WIDTH(fmc_pkg::DATA_W),
      .DEPTH(fmc_pkg::NUM_REGS),
      .AW(fmc_pkg::IDX_W),
      .RST_VAL(fmc_pkg::MEM_RST)
   ) u_mem (
      .clk(ref_clk),
      .rst(rst),
      .we(mem_we),
      .waddr(reg_addr[fmc_pkg::IDX_W-1:0]),
      .wdata(mem_wdata),
      .raddr(reg_addr[fmc_pkg::IDX_W-1:0]),
      .rdata(mem_rdata)
   );

   // enable is low while the port drives, following the synchronised select
   assign spi_miso = miso_r;
   assign spi_miso_en_n = cs_s_r[1]; // drive only while selected

   // modem-facing controls, all registered
   logic rts_n_r, rts_n_nxt;
   logic [fmc_pkg::GPIO_W-1:0] gpio_r, gpio_nxt;

   always_comb begin
      // test mode forces rts low (active) so the receive path runs functionally
      rts_n_nxt = ctrl_test_r ? 1'b0 : rts_s_r[1]; // [R07]
      // adc result bits 7:2 go out on gpio 5:0 for linearity measurement
      gpio_nxt = ctrl_test_r ? rx_adc_result[fmc_pkg::ADC_W-1:fmc_pkg::ADC_TAP_LSB] : gpio_func_out; // [R08]
   end

   // one register stage keeps the pins free of glitches when the mode flips
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rts_n_r <= 1'b1;
         gpio_r <= '0;
      end else begin
         rts_n_r <= rts_n_nxt;
         gpio_r <= gpio_nxt;
      end
   end

   // the modem enable gate lives outside; this bit only requests the mode
   assign adc_linearity_test_enable = ctrl_test_r; // [R05]
   assign rx_functional_mode = ctrl_test_r; // [R07]
   assign modem_rts_n = rts_n_r;
   assign gpio_out = gpio_r;
   // transmit and receive settings go straight out of the stored word
   assign tx_slew_clock_select = rxtx_r[fmc_pkg::RXTX_SLEW_CLK_POS]; // [R09]
   assign tx_disable_edge_select = rxtx_r[fmc_pkg::RXTX_DIS_EDGE_POS]; // [R11]
   assign tx_bus_dc_load_select = rxtx_r[fmc_pkg::RXTX_DC_LOAD_POS];
   assign tx_buffer_enable = rxtx_r[fmc_pkg::RXTX_BUF_EN_POS]; // [R12]
   assign rx_power_up_ignore_count =
      rxtx_r[fmc_pkg::RXTX_PWR_DLY_LSB +: fmc_pkg::RXTX_PWR_DLY_W]; // [R13]
   assign rx_bandpass_settle_count =
      rxtx_r[fmc_pkg::RXTX_BP_SETTLE_LSB +: fmc_pkg::RXTX_BP_SETTLE_W]; // [R15]

endmodule

`default_nettype wire

// ### testbench/fmc_regs_props.sv
`default_nettype none

module fmc_regs_props (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic spi_cs_n,
   input wire logic spi_miso,
   input wire logic spi_miso_en_n,
   input wire logic [7:0] rx_adc_result,
   input wire logic [5:0] gpio_func_out,
   input wire logic adc_linearity_test_enable,
   input wire logic modem_rts_n,
   input wire logic rx_functional_mode,
   input wire logic [5:0] gpio_out,
   input wire logic tx_slew_clock_select,
   input wire logic tx_disable_edge_select,
   input wire logic tx_bus_dc_load_select,
   input wire logic tx_buffer_enable,
   input wire logic [3:0] rx_power_up_ignore_count,
   input wire logic [7:0] rx_bandpass_settle_count
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   // test mode pins: two cycles of enable so either mux timing passes
   a_rts_forced: assert property (
      adc_linearity_test_enable && $past(adc_linearity_test_enable) |-> !modem_rts_n)
      else $error("rts not forced in test mode");
   a_gpio_tap: assert property (
      adc_linearity_test_enable && $past(adc_linearity_test_enable) |-> gpio_out == $past(rx_adc_result[7:2]))
      else $error("gpio does not carry adc bits");
   a_gpio_normal: assert property (
      !$past(rst) && !adc_linearity_test_enable && !$past(adc_linearity_test_enable)
      |-> gpio_out == $past(gpio_func_out))
      else $error("gpio does not carry function values");
   a_rx_mode: assert property (rx_functional_mode == adc_linearity_test_enable)
      else $error("receive mode differs from test enable");
   // serial port idle and active; sync delay covered by the five cycles
   a_miso_idle: assert property (spi_cs_n [*5] |-> spi_miso_en_n && !spi_miso)
      else $error("miso driven while deselected");
   a_miso_enable: assert property ((!spi_cs_n) [*5] |-> !spi_miso_en_n)
      else $error("miso not enabled in frame");
   // config outputs only move inside a frame
   a_cfg_stable: assert property (spi_cs_n [*5] |=> $stable({adc_linearity_test_enable,
      tx_slew_clock_select, tx_disable_edge_select, tx_bus_dc_load_select, tx_buffer_enable,
      rx_power_up_ignore_count, rx_bandpass_settle_count}))
      else $error("config changed outside a frame");
   a_reset_values: assert property ($past(rst) |->
      tx_slew_clock_select && !tx_disable_edge_select && tx_buffer_enable && tx_bus_dc_load_select
      && rx_power_up_ignore_count == 4'h2 && rx_bandpass_settle_count == 8'h50
      && !adc_linearity_test_enable && modem_rts_n)
      else $error("wrong values after reset");
endmodule

bind fmc_regs fmc_regs_props chk (.ref_clk, .rst, .spi_cs_n, .spi_miso, .spi_miso_en_n, .rx_adc_result,
   .gpio_func_out, .adc_linearity_test_enable, .modem_rts_n, .rx_functional_mode, .gpio_out,
   .tx_slew_clock_select, .tx_disable_edge_select, .tx_bus_dc_load_select, .tx_buffer_enable,
   .rx_power_up_ignore_count, .rx_bandpass_settle_count);

`default_nettype wire

// ### testbench/fmc_spi_ctl.sv
`default_nettype none

// internal serial controller, mode 0, half period of 8 ref_clk cycles
module fmc_spi_ctl (
   input wire logic ref_clk,
   output logic spi_sclk,
   output logic spi_cs_n,
   output logic spi_mosi,
   input wire logic spi_miso
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      spi_sclk = 1'b0;
      spi_cs_n = 1'b1;
      spi_mosi = 1'b0;
   end

   // the only path to the registers; nbits below 32 aborts the frame
   // callers keep the modem disabled around writes
   task automatic xfer(input logic [7:0] cmd, input logic [23:0] wd, input int nbits, output logic [23:0] rd);
      logic [31:0] sh;
      sh = {cmd, wd};
      rd = 24'h000000;
      @(posedge ref_clk) spi_cs_n <= 1'b0;
      for (int i = 0; i < nbits; i++) begin
         spi_mosi <= sh[31-i];
         repeat (8) @(posedge ref_clk);
         spi_sclk <= 1'b1;
         if (i >= 8) rd = {rd[22:0], spi_miso}; // whole 24-bit word
         repeat (8) @(posedge ref_clk);
         spi_sclk <= 1'b0;
      end
      repeat (8) @(posedge ref_clk);
      spi_cs_n <= 1'b1;
      // released data line must not look like the last bit
      spi_mosi <= ~spi_mosi;
      repeat (8) @(posedge ref_clk);
   endtask
endmodule

`default_nettype wire

// ### testbench/tb_top.sv
`default_nettype none

module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk, rst, spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_en_n, rts_gpio_n;
   logic adc_linearity_test_enable, modem_rts_n, rx_functional_mode, tx_slew_clock_select;
   logic tx_disable_edge_select, tx_bus_dc_load_select, tx_buffer_enable;
   logic [7:0] rx_adc_result, rx_bandpass_settle_count;
   logic [5:0] gpio_func_out, gpio_out;
   logic [3:0] rx_power_up_ignore_count;
   logic [23:0] modem_status, rdw;
   wire miso_w;
   int miscompares, checks;

   // undriven miso reads as unknown and can never match
   assign miso_w = spi_miso_en_n ? 1'bz : spi_miso;

   fmc_regs dut (.ref_clk, .rst, .spi_sclk, .spi_cs_n, .spi_mosi, .spi_miso, .spi_miso_en_n, .rts_gpio_n,
      .rx_adc_result, .gpio_func_out, .modem_status, .adc_linearity_test_enable, .modem_rts_n,
      .rx_functional_mode, .gpio_out, .tx_slew_clock_select, .tx_disable_edge_select, .tx_bus_dc_load_select,
      .tx_buffer_enable, .rx_power_up_ignore_count, .rx_bandpass_settle_count);
   fmc_spi_ctl ctl (.ref_clk, .spi_sclk, .spi_cs_n, .spi_mosi, .spi_miso(miso_w));

   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end

   task automatic final_report();
      if (miscompares == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic cmp_word(input logic [23:0] got, input logic [23:0] exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch %0t word %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cmp_pin(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch %0t pins %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [6:0] a, input logic [23:0] d);
      logic [23:0] x;
      ctl.xfer({1'b0, a}, d, 32, x);
   endtask

   task automatic rd(input logic [6:0] a, output logic [23:0] d);
      ctl.xfer({1'b1, a}, 24'h000000, 32, d);
   endtask

   function automatic logic [23:0] pat(input logic [6:0] k);
      return 24'h3c5a69 ^ {3{1'b0, k}};
   endfunction

   task automatic t_reset();
      rd(7'h01, rdw);
      cmp_word(rdw, 24'hb25043);
      rd(7'h00, rdw);
      cmp_word(rdw, 24'h000000);
      cmp_pin({tx_slew_clock_select, tx_disable_edge_select, tx_bus_dc_load_select, tx_buffer_enable,
         rx_power_up_ignore_count}, 8'hb2);
      cmp_pin(rx_bandpass_settle_count, 8'h50);
   endtask

   // every mapped address plus 0x0c written, status and control reserved bits read back fixed
   task automatic t_rw_all();
      for (int i = 0; i < 12; i++) wr(i[6:0], pat(i[6:0]));
      for (int i = 0; i < 12; i++) begin
         rd(i[6:0], rdw);
         cmp_word(rdw, i == 9 ? modem_status : i == 0 ? (pat(7'h00) & 24'h000001) : pat(i[6:0]));
      end
      wr(7'h0c, 24'hffffff);
      rd(7'h0c, rdw);
      cmp_word(rdw, 24'h000000);
      rd(7'h7f, rdw);
      cmp_word(rdw, 24'h000000);
      wr(7'h00, 24'h000000);
   endtask

   // both values of each field in bits 23:8 written at 0x01; mark/space counts at 0x08 are not rewritten
   task automatic t_fields();
      logic [23:0] v[2];
      v = '{24'h4fa500, 24'hb05a00};
      for (int i = 0; i < 2; i++) begin
         wr(7'h01, v[i]);
         cmp_pin({tx_slew_clock_select, tx_disable_edge_select, tx_bus_dc_load_select, tx_buffer_enable,
            rx_power_up_ignore_count}, v[i][23:16]);
         cmp_pin(rx_bandpass_settle_count, v[i][15:8]);
      end
   endtask

   // front-end modem enable gating lives outside this block
   task automatic t_test();
      wr(7'h00, 24'hffffff);
      @(posedge ref_clk) rx_adc_result <= 8'hb4;
      repeat (4) @(posedge ref_clk);
      cmp_pin(8'(modem_rts_n), 8'h00);
      cmp_pin(8'(rx_functional_mode), 8'h01);
      cmp_pin(8'(adc_linearity_test_enable), 8'h01);
      cmp_pin(8'(gpio_out), 8'h2d);
      wr(7'h00, 24'h000000);
      cmp_pin(8'(modem_rts_n), 8'h01);
      cmp_pin(8'(rx_functional_mode), 8'h00);
      cmp_pin(8'(gpio_out), 8'h15);
      @(posedge ref_clk) rts_gpio_n <= 1'b0;
      gpio_func_out <= 6'h2a;
      repeat (5) @(posedge ref_clk);
      cmp_pin(8'(modem_rts_n), 8'h00);
      cmp_pin(8'(gpio_out), 8'h2a);
   endtask

   task automatic t_abort();
      ctl.xfer(8'h01, 24'hffffff, 20, rdw);
      rd(7'h01, rdw);
      cmp_word(rdw, 24'hb05a00);
   endtask

   task automatic t_midreset();
      wr(7'h02, 24'h0abcde);
      @(posedge ref_clk) rst <= 1'b1;
      repeat (3) @(posedge ref_clk);
      rst <= 1'b0;
      repeat (3) @(posedge ref_clk);
      rd(7'h02, rdw);
      cmp_word(rdw, 24'h000000);
      rd(7'h01, rdw);
      cmp_word(rdw, 24'hb25043);
   endtask

   // cut a hang short
   initial begin
      repeat (100000) @(posedge ref_clk);
      miscompares++;
      final_report();
   end

   initial begin
      rst = 1'b1;
      rts_gpio_n = 1'b1;
      rx_adc_result = 8'h00;
      gpio_func_out = 6'h15;
      modem_status = 24'h5a3c96;
      miscompares = 0;
      checks = 0;
      repeat (3) @(posedge ref_clk);
      rst <= 1'b0;
      repeat (3) @(posedge ref_clk);
      t_reset();
      t_rw_all();
      t_fields();
      t_test();
      t_abort();
      t_midreset();
      final_report();
   end
endmodule

`default_nettype wire
